// >>> src/shb_host_port.sv
`timescale 1ns/1ps

// two-entry buffer; ready is a flop so the source sees honest back-pressure
module shb_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 2
)(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   level;
	logic [AW:0]   next_level;
	logic          push;
	logic          pop;

	always_comb
	begin
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		next_level = level + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			level <= next_level;
			in_ready <= (next_level != (AW+1)'(DEPTH));
			out_valid <= (next_level != '0);
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	assign out_data = mem[rd_ptr];
endmodule

module shb_host_port
	import shb_pkg::*;
(
	// clock and reset
	input  wire logic                      MCLK,
	input  wire logic                      RESETN,
	// host bus
	input  wire logic                      CS_N,
	input  wire logic                      RD_N,
	input  wire logic                      WR_N,
	input  wire logic                      COMMAND_DATA_SELECT,
	input  wire logic [shb_pkg::DATA_W-1:0] DB_IN,
	output logic      [shb_pkg::DATA_W-1:0] DB_OUT,
	output logic                           DB_OE,
	// port 2 upper pins, index 0 is bit 4
	input  wire logic [shb_pkg::NIB_W-1:0]  P2_IN,
	output logic      [shb_pkg::NIB_W-1:0]  P2_OUT,
	// core control
	input  wire logic                      STATUS_LOAD,
	input  wire logic [shb_pkg::NIB_W-1:0]  STATUS_ACC,
	input  wire logic                      USER_FLAG0_WRITE,
	input  wire logic                      USER_FLAG0_VALUE,
	input  wire logic                      EN_FLAGS,
	input  wire logic                      EN_DMA,
	input  wire logic                      P2_WRITE,
	input  wire logic [shb_pkg::NIB_W-1:0]  P2_WDATA,
	// core to host stream
	input  wire logic                      OUT_VALID,
	input  wire logic [shb_pkg::DATA_W-1:0] OUT_DATA,
	output logic                           OUT_READY,
	// host to core
	output logic                           IN_FULL,
	output logic      [shb_pkg::DATA_W-1:0] IN_DATA,
	output logic                           IN_COMMAND,
	input  wire logic                      IN_TAKE,
	output logic      [shb_pkg::DATA_W-1:0] STATUS,
	// sequencing
	input  wire logic                      SINGLE_STEP_N,
	output logic                           INSTR_STROBE,
	output logic      [shb_pkg::PC_W-1:0]   PROGRAM_COUNTER
);
	import shb_pkg::*;

	logic [SYNC_STAGES-1:0] rst_sync;
	logic                   rst_n;

	logic              flags_en;
	logic              dma_en;
	logic [NIB_W-1:0]  p2_latch;
	logic              dma_request;
	logic              dma_acknowledge;
	logic              sel;

	logic              rd_busy;
	logic              rd_status;
	logic              rd_dma;
	logic              rd_done;
	logic              wr_busy;
	logic              wr_cmd;
	logic              wr_dma;
	logic [DATA_W-1:0] wr_data;
	logic              wr_done;
	logic              lock;

	logic [DATA_W-1:0] ibuf;
	logic [DATA_W-1:0] obuf;
	logic              input_buffer_full;
	logic              output_buffer_full;
	logic              f0;
	logic              f1;
	logic [NIB_W-1:0]  user_bits;
	logic [DATA_W-1:0] status_byte;

	logic              sts_pend;
	logic [NIB_W-1:0]  sts_pend_val;
	logic              f0_pend;
	logic              f0_pend_val;
	logic              take_pend;

	logic              fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	logic              drain;

	logic [CNT_W-1:0]  cyc_cnt;
	logic              ss_q;
	logic              step_req;
	logic              cyc_end;
	logic              go;

	// release is synchronised so every flop leaves reset on the same edge
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			rst_sync <= '0;
		else
			rst_sync <= {rst_sync[SYNC_STAGES-2:0], 1'b1}; // see [R17]
	end
	assign rst_n = rst_sync[SYNC_STAGES-1];

	// acknowledge only counts once dma mode is on
	always_comb
	begin
		dma_acknowledge = dma_en & ~P2_IN[P2_B7]; // see [R15]
		sel = ~CS_N | dma_acknowledge; // see [R7]
		rd_done = rd_busy & RD_N; // see [R5]
		wr_done = wr_busy & WR_N; // see [R5]
		status_byte = {user_bits, f1, f0, input_buffer_full, output_buffer_full}; // see [R1]
		lock = rd_busy & rd_status; // see [R6]
		drain = fifo_valid & ~output_buffer_full & ~lock;
		cyc_end = (cyc_cnt == CNT_LAST);
		go = SINGLE_STEP_N | step_req; // see [R19]
	end

	// strobe tracking: a strobe once started is followed to its trailing edge
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_busy <= 1'b0;
			rd_status <= 1'b0;
			rd_dma <= 1'b0;
		end
		else
		begin
			rd_busy <= ~RD_N & (rd_busy | sel);
			if (!rd_busy)
			begin
				rd_status <= ~dma_acknowledge & COMMAND_DATA_SELECT; // see [R20]
				rd_dma <= dma_acknowledge;
			end
		end
	end

	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_busy <= 1'b0;
			wr_cmd <= 1'b0;
			wr_dma <= 1'b0;
			wr_data <= BYTE_RESET;
		end
		else
		begin
			wr_busy <= ~WR_N & (wr_busy | sel);
			if (!wr_busy)
			begin
				wr_cmd <= ~dma_acknowledge & COMMAND_DATA_SELECT; // see [R2]
				wr_dma <= dma_acknowledge;
			end
			// data is sampled right up to the trailing edge
			if (!WR_N)
				wr_data <= DB_IN;
		end
	end

	// bus drive: one cycle behind the strobe, and off one cycle after it ends
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			DB_OE <= 1'b0;
			DB_OUT <= BYTE_RESET;
		end
		else
		begin
			DB_OE <= ~RD_N & (rd_busy | sel); // see [R8]
			DB_OUT <= (rd_busy ? rd_status : (~dma_acknowledge & COMMAND_DATA_SELECT)) ? status_byte : obuf; // see [R3]
		end
	end

	// input buffer and command flag
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ibuf <= BYTE_RESET;
			input_buffer_full <= 1'b0;
			f1 <= 1'b0;
			take_pend <= 1'b0;
		end
		else
		begin
			if (IN_TAKE)
				take_pend <= 1'b1;
			if ((IN_TAKE | take_pend) & ~lock)
			begin
				input_buffer_full <= 1'b0;
				take_pend <= 1'b0;
			end
			// a host write wins over a same-cycle take
			if (wr_done)
			begin
				ibuf <= wr_data; // see [R4] [R9]
				input_buffer_full <= 1'b1; // see [R21]
				f1 <= wr_cmd; // see [R2]
			end
		end
	end

	// output buffer, fed from the two-entry buffer only when empty
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			obuf <= BYTE_RESET;
			output_buffer_full <= 1'b0;
		end
		else
		begin
			if (rd_done & ~rd_status)
				output_buffer_full <= 1'b0; // see [R20]
			if (drain)
			begin
				obuf <= fifo_data; // see [R9]
				output_buffer_full <= 1'b1; // see [R21]
			end
		end
	end

	shb_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_out_fifo (
		.clk       (MCLK),
		.rst_n     (rst_n),
		.in_valid  (OUT_VALID),
		.in_data   (OUT_DATA),
		.in_ready  (OUT_READY),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (drain)
	);

	// core status writes wait out a host status read instead of being lost
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			user_bits <= NIB_RESET; // see [R16]
			f0 <= 1'b0;
			sts_pend <= 1'b0;
			sts_pend_val <= NIB_RESET;
			f0_pend <= 1'b0;
			f0_pend_val <= 1'b0;
		end
		else
		begin
			if (lock)
			begin
				if (STATUS_LOAD)
				begin
					sts_pend <= 1'b1; // see [R6]
					sts_pend_val <= STATUS_ACC;
				end
				if (USER_FLAG0_WRITE)
				begin
					f0_pend <= 1'b1;
					f0_pend_val <= USER_FLAG0_VALUE;
				end
			end
			else
			begin
				sts_pend <= 1'b0;
				f0_pend <= 1'b0;
				if (STATUS_LOAD)
					user_bits <= STATUS_ACC; // see [R1]
				else if (sts_pend)
					user_bits <= sts_pend_val;
				if (USER_FLAG0_WRITE)
					f0 <= USER_FLAG0_VALUE;
				else if (f0_pend)
					f0 <= f0_pend_val;
			end
		end
	end

	// port 2 mode and latch
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_en <= 1'b0; // see [R10]
			dma_en <= 1'b0;
			p2_latch <= P2_LATCH_RESET;
			dma_request <= 1'b0;
		end
		else
		begin
			if (EN_FLAGS)
				flags_en <= 1'b1;
			if (EN_DMA)
				dma_en <= 1'b1;
			if (P2_WRITE)
				p2_latch <= P2_WDATA;
			if (EN_DMA | (rd_done & rd_dma) | (wr_done & wr_dma))
				dma_request <= 1'b0; // see [R14]
			// a new request wins over a same-cycle clear
			if (P2_WRITE & P2_WDATA[P2_B6] & (dma_en | EN_DMA))
				dma_request <= 1'b1; // see [R13]
		end
	end

	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
			P2_OUT <= P2_LATCH_RESET;
		else
		begin
			P2_OUT[P2_B4] <= flags_en ? (p2_latch[P2_B4] & output_buffer_full) : p2_latch[P2_B4]; // see [R11]
			P2_OUT[P2_B5] <= flags_en ? (p2_latch[P2_B5] & ~input_buffer_full) : p2_latch[P2_B5]; // see [R12]
			P2_OUT[P2_B6] <= dma_en ? dma_request : p2_latch[P2_B6]; // see [R13]
			// released high so the acknowledge can pull it low
			P2_OUT[P2_B7] <= dma_en | p2_latch[P2_B7]; // see [R15]
		end
	end

	// core-facing views
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			IN_FULL <= 1'b0;
			IN_DATA <= BYTE_RESET;
			IN_COMMAND <= 1'b0;
			STATUS <= BYTE_RESET;
		end
		else
		begin
			IN_FULL <= input_buffer_full;
			IN_DATA <= ibuf;
			IN_COMMAND <= f1;
			STATUS <= status_byte;
		end
	end

	// instruction cycle timing; stepping holds at the cycle end
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cyc_cnt <= CNT_ZERO;
			ss_q <= 1'b1;
			step_req <= 1'b0;
			INSTR_STROBE <= 1'b0;
			PROGRAM_COUNTER <= PC_RESET; // see [R16]
		end
		else
		begin
			ss_q <= SINGLE_STEP_N;
			INSTR_STROBE <= 1'b0;
			if (!cyc_end)
				cyc_cnt <= cyc_cnt + CNT_ONE;
			else if (go)
			begin
				cyc_cnt <= CNT_ZERO;
				INSTR_STROBE <= 1'b1; // see [R18]
				PROGRAM_COUNTER <= PROGRAM_COUNTER + PC_STEP; // see [R19]
				step_req <= 1'b0;
			end
			// a rising step input is one request; at the cycle end the level already steps,
			// so remembering it there as well would run a second instruction
			if (SINGLE_STEP_N & ~ss_q & ~cyc_end)
				step_req <= 1'b1; // see [R19]
		end
	end
endmodule

// >>> pkg/shb_pkg.sv
// Functional notes
// [R1] status byte: user bits 7..4, command flag 3, user flag 2, INPUT_BUFFER_FULL-like 1, OUTPUT_BUFFER_FULL-like 0
// [R2] host write with select low clears command flag, with select high sets it
// [R3] host read returns output buffer or status byte on the data bus
// [R4] host write loads data or command byte into the input buffer
// [R5] buffer flags and command flag change only after the strobe's trailing edge
// [R6] internal status updates are held off while the host reads status
// [R7] strobes are honoured only while chip select is asserted
// [R8] eight-bit data bus drives only during selected host reads
// [R9] separate input and output data buffers
// [R10] upper port 2 pins are plain port pins after reset
// [R11] flag mode: bit 4 follows output_buffer_full when its latch is one, else low
// [R12] flag mode: bit 5 shows inverse input_buffer_full when its latch is one, else low
// [R13] dma mode: writing one to bit 6 raises dma_request
// [R14] dma_request drops on acknowledged strobe or on repeated dma enable
// [R15] dma mode: bit 7 is dma_acknowledge, acting as buffer chip select
// [R16] reset clears status flip-flops and zeroes the program counter
// [R17] reset passes through a two-stage synchroniser before use
// [R18] one instruction strobe pulse per instruction cycle
// [R19] single step input advances exactly one instruction per step
// [R20] read with select high gives status; low gives data and clears output_buffer_full
// [R21] host write sets input_buffer_full; internal output load sets output_buffer_full
package shb_pkg;
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int PC_W = 10;
	localparam int FIFO_DEPTH = 2;
	localparam int SYNC_STAGES = 2;

	localparam int ST_OBF = 0;
	localparam int ST_IBF = 1;
	localparam int ST_F0 = 2;
	localparam int ST_F1 = 3;

	localparam int P2_B4 = 0;
	localparam int P2_B5 = 1;
	localparam int P2_B6 = 2;
	localparam int P2_B7 = 3;

	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
	localparam logic [NIB_W-1:0] P2_LATCH_RESET = 4'hF;
	localparam logic [PC_W-1:0] PC_RESET = 10'h000;
	localparam logic [PC_W-1:0] PC_STEP = 10'h001;

	localparam int CLK_PERIOD_NS = 10;
	localparam int INSTR_CYCLE_NS = 150;
	localparam int CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLE_CLKS - 1);
endpackage

// >>> dv/shb_host_port_props.sv
`timescale 1ns/1ps
module shb_host_port_props
	import shb_pkg::*;
(
	// host bus
	input wire logic	MCLK,
	input wire logic	RESETN,
	input wire logic	CS_N,
	input wire logic	RD_N,
	input wire logic	WR_N,
	input wire logic	COMMAND_DATA_SELECT,
	input wire logic	DB_OE,
	// port pins
	input wire logic [shb_pkg::NIB_W-1:0]	P2_IN,
	input wire logic [shb_pkg::NIB_W-1:0]	P2_OUT,
	input wire logic	EN_DMA,
	input wire logic	P2_WRITE,
	// core side
	input wire logic	IN_FULL,
	input wire logic	IN_COMMAND,
	input wire logic [shb_pkg::DATA_W-1:0]	STATUS,
	input wire logic	INSTR_STROBE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	// saturates so a long single-step wait never wraps into a short gap
	logic [7:0]	gap;
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			gap <= 8'hFF;
		else if (INSTR_STROBE)
			gap <= 8'h01;
		else if (gap != 8'hFF)
			gap <= gap + 8'h01;
	end
	property cmd_follows_select;
		logic a;
		($past(!WR_N && !CS_N && P2_IN[3]) && WR_N, a = $past(COMMAND_DATA_SELECT)) |-> ##2 IN_COMMAND == a;
	endproperty
	chk_oe_read: assert property (DB_OE |-> $past(!RD_N))
		else $error("bus driven outside read");
	chk_read_select: assert property ($rose(DB_OE) |-> $past(!CS_N || !P2_IN[3]))
		else $error("read without select");
	chk_status_lock: assert property (DB_OE && $past(DB_OE, 2) && COMMAND_DATA_SELECT |-> $stable(STATUS[7:4]))
		else $error("status moved during read");
	chk_ibf_set: assert property ($past(!WR_N && !CS_N) && WR_N |-> ##2 IN_FULL)
		else $error("write left input empty");
	chk_ibf_trailing: assert property ($rose(IN_FULL) |-> $past(WR_N, 2) && $past(!WR_N, 3))
		else $error("input flag before write end");
	chk_obf_clear: assert property ($past(!RD_N && !CS_N && !COMMAND_DATA_SELECT) && RD_N |-> ##2 !STATUS[0])
		else $error("data read kept output flag");
	chk_cmd_flag: assert property (cmd_follows_select)
		else $error("command flag wrong");
	chk_drq_ack: assert property ($past(!(RD_N && WR_N) && !P2_IN[3]) && RD_N && WR_N && !P2_WRITE |-> ##3 !P2_OUT[2])
		else $error("request kept after ack");
	chk_drq_enable: assert property (EN_DMA && !P2_WRITE |-> ##3 !P2_OUT[2])
		else $error("request kept after enable");
	chk_strobe_pace: assert property (INSTR_STROBE |-> gap >= 8'h0F)
		else $error("strobe too early");
	cover property (DB_OE && COMMAND_DATA_SELECT);
	cover property (!P2_IN[3] && !RD_N);
	cover property (INSTR_STROBE && gap > 8'h20);
endmodule

bind shb_host_port shb_host_port_props chk_u (.MCLK, .RESETN, .CS_N, .RD_N, .WR_N, .COMMAND_DATA_SELECT, .DB_OE,
	.P2_IN, .P2_OUT, .EN_DMA, .P2_WRITE, .IN_FULL, .IN_COMMAND, .STATUS, .INSTR_STROBE);

// >>> dv/shb_host_model.sv
`timescale 1ns/1ps
module shb_host_model
	import shb_pkg::*;
(
	// bus from the device
	input wire logic	MCLK,
	input wire logic [shb_pkg::DATA_W-1:0]	DB_OUT,
	// host and dma controller
	output logic	CS_N,
	output logic	RD_N,
	output logic	WR_N,
	output logic	A0,
	output logic [shb_pkg::DATA_W-1:0]	DB_IN,
	output logic	DMA_ACKNOWLEDGE_N
);
	initial
	begin
		CS_N = 1'b1;
		RD_N = 1'b1;
		WR_N = 1'b1;
		A0 = 1'b0;
		DB_IN = 8'h00;
		DMA_ACKNOWLEDGE_N = 1'b1;
	end
	// strobe held over three edges; dma_acknowledge replaces chip select
	task automatic xfer(input logic wr, a, dk, sel, input logic [7:0] d, output logic [7:0] q);
		@(negedge MCLK);
		CS_N = ~sel;
		DMA_ACKNOWLEDGE_N = ~dk;
		A0 = a;
		DB_IN = d;
		WR_N = ~wr;
		RD_N = wr;
		repeat (3) @(posedge MCLK);
		@(negedge MCLK);
		q = DB_OUT;
		CS_N = 1'b1;
		WR_N = 1'b1;
		RD_N = 1'b1;
		DMA_ACKNOWLEDGE_N = 1'b1;
		// released bus must not look like the last byte
		DB_IN = ~d;
		repeat (4) @(negedge MCLK);
	endtask
endmodule

// >>> dv/shb_host_port_tb.sv
`timescale 1ns/1ps
module shb_host_port_tb;
	import shb_pkg::*;
	logic	mclk = 1'b0;
	logic	resetn = 1'b0;
	logic	cs_n, rd_n, wr_n, a0, dma_acknowledge_n, db_oe, out_ready, in_full, in_cmd, strobe;
	logic	ld = 1'b0, f0_wr = 1'b0, en_flags = 1'b0, en_dma = 1'b0, p2_wr = 1'b0;
	logic	out_valid = 1'b0, in_take = 1'b0, step_n = 1'b1;
	logic [7:0]	db_in, db_out, in_data, status, q;
	logic [7:0]	out_data = 8'h00;
	logic [3:0]	p2_out;
	logic [3:0]	acc = 4'h0;
	logic [3:0]	p2_wdata = 4'h0;
	logic [9:0]	pc, pc0;
	int	fails = 0, check_count = 0, n;
	always #5 mclk = ~mclk;
	shb_host_port dut_u (.MCLK(mclk), .RESETN(resetn), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
		.COMMAND_DATA_SELECT(a0), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .P2_IN({dma_acknowledge_n, 3'h5}),
		.P2_OUT(p2_out), .STATUS_LOAD(ld), .STATUS_ACC(acc), .USER_FLAG0_WRITE(f0_wr), .USER_FLAG0_VALUE(1'b1),
		.EN_FLAGS(en_flags), .EN_DMA(en_dma), .P2_WRITE(p2_wr), .P2_WDATA(p2_wdata), .OUT_VALID(out_valid),
		.OUT_DATA(out_data), .OUT_READY(out_ready), .IN_FULL(in_full), .IN_DATA(in_data), .IN_COMMAND(in_cmd),
		.IN_TAKE(in_take), .STATUS(status), .SINGLE_STEP_N(step_n), .INSTR_STROBE(strobe), .PROGRAM_COUNTER(pc));
	shb_host_model host_u (.MCLK(mclk), .DB_OUT(db_out), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .A0(a0),
		.DB_IN(db_in), .DMA_ACKNOWLEDGE_N(dma_acknowledge_n));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
	task automatic hr(input logic a, dk, input logic [7:0] exp);
		host_u.xfer(1'b0, a, dk, ~dk, 8'h00, q);
		check(q, exp);
	endtask
	// waits on ready with a bound; a stuck buffer shows up as a count mismatch later
	task automatic push(input logic [7:0] d);
		@(negedge mclk);
		out_valid = 1'b1;
		out_data = d;
		n = 0;
		while (out_ready !== 1'b1 && n < 50)
		begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		out_valid = 1'b0;
	endtask
	task automatic cnt(input int c);
		n = 0;
		repeat (c) @(negedge mclk) if (strobe === 1'b1) n++;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge mclk);
		fails++;
		print_verdict();
	end
	initial
	begin
		repeat (12) @(negedge mclk);
		check(pc, 10'h000);
		check(p2_out, 4'hF);
		check(status, 8'h00);
		check(db_oe, 1'b0);
		resetn = 1'b1;
		ld = 1'b1;
		acc = 4'hF;
		@(negedge mclk);
		ld = 1'b0;
		repeat (4) @(negedge mclk);
		check(status, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 2; i++)
		begin
			host_u.xfer(1'b1, i[0], 1'b0, 1'b1, 8'h3C + 8'(i), q);
			check(in_data, 8'h3C + 8'(i));
			check(in_cmd, i[0]);
			check(status[3:0], {i[0], 3'h2});
			pulse(in_take);
			check(in_full, 1'b0);
		end
		host_u.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h77, q);
		check(in_full, 1'b0);
		check(db_oe, 1'b0);
		$display("host write test done");
		acc = 4'hA;
		pulse(ld);
		pulse(f0_wr);
		hr(1'b1, 1'b0, 8'hAC);
		$display("status test done");
		push(8'h11);
		push(8'h22);
		push(8'h33);
		repeat (4) @(negedge mclk);
		check({out_ready, in_full, status[0]}, 3'h1);
		for (int k = 1; k < 4; k++)
			hr(1'b0, 1'b0, 8'(8'h11 * k));
		check(status[0], 1'b0);
		$display("output buffer test done");
		pulse(en_flags);
		p2_wdata = 4'h3;
		pulse(p2_wr);
		check(p2_out, 4'h2);
		host_u.xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'h5A, q);
		check(p2_out[1], 1'b0);
		push(8'h66);
		repeat (4) @(negedge mclk);
		check(p2_out[0], 1'b1);
		p2_wdata = 4'h0;
		pulse(p2_wr);
		check(p2_out[1:0], 2'h0);
		pulse(in_take);
		$display("flag pin test done");
		pulse(en_dma);
		p2_wdata = 4'h4;
		pulse(p2_wr);
		check(p2_out[3:2], 2'h3);
		hr(1'b0, 1'b1, 8'h66);
		check(p2_out[2], 1'b0);
		pulse(p2_wr);
		pulse(en_dma);
		check(p2_out[2], 1'b0);
		$display("dma test done");
		@(posedge strobe);
		repeat (3) @(negedge mclk);
		pc0 = pc;
		cnt(150);
		check(16'(n), 16'h000A);
		check(pc - pc0, 10'h00A);
		step_n = 1'b0;
		cnt(40);
		cnt(40);
		check(16'(n), 16'h0000);
		// stalled at the cycle end: one high cycle of the step input is one instruction
		pc0 = pc;
		step_n = 1'b1;
		cnt(1);
		step_n = 1'b0;
		cnt(40);
		check(16'(n), 16'h0000);
		check(pc - pc0, 10'h001);
		step_n = 1'b1;
		$display("strobe test done");
		print_verdict();
	end
endmodule
